// *** common/ddr_capture_regs.vh ***
// register map, field positions and constants of the transmit parallel capture
`ifndef DDR_CAPTURE_REGS_VH
`define DDR_CAPTURE_REGS_VH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define CAP_OFS_CTRL        12'h000
`define CAP_OFS_STATUS      12'h004
`define CAP_OFS_LEVEL       12'h008

// ----------------------------------------------------------------------------
// control fields
// ----------------------------------------------------------------------------
`define CAP_CTRL_NIBBLE     0
`define CAP_CTRL_INDEP      1
`define CAP_CTRL_CODE       2
`define CAP_CTRL_ENABLE     3
`define CAP_CTRL_WIDTH      4
`define CAP_CTRL_RESET      4'h0

// ----------------------------------------------------------------------------
// status and level fields
// ----------------------------------------------------------------------------
`define CAP_STAT_OVF_LSB    0
`define CAP_STAT_EMPTY_LSB  4
`define CAP_STAT_FULL_LSB   8
`define CAP_LEVEL_STRIDE    8

// ----------------------------------------------------------------------------
// sizes
// ----------------------------------------------------------------------------
`define CAP_PAIRS           3
`define CAP_BUS_W           10
`define CAP_FIFO_DEPTH      16
`define CAP_FIFO_AW         4

`endif

// *** logic/capture_fifo.v ***
// synchronous fifo with valid/ready on both sides and a fill level
module capture_fifo #(
   parameter WIDTH  = 22,
   parameter DEPTH  = 16,
   parameter ADDR_W = 4
) (
   input  wire              clk,
   input  wire              rst,
   input  wire              ce,
   input  wire              inValid,
   output wire              inReady,
   input  wire [WIDTH-1:0]  inData,
   output wire              outValid,
   input  wire              outReady,
   output wire [WIDTH-1:0]  outData,
   output wire [ADDR_W:0]   level
);
   reg  [WIDTH-1:0]  mem [0:DEPTH-1];
   reg  [ADDR_W-1:0] wrPtr;
   reg  [ADDR_W-1:0] rdPtr;
   reg  [ADDR_W:0]   count;
   wire              push;
   wire              pop;

   assign inReady  = (count != DEPTH[ADDR_W:0]);
   assign outValid = (count != {(ADDR_W+1){1'b0}});
   assign outData  = mem[rdPtr];
   assign level    = count;
   assign push     = ce & inValid & inReady;
   assign pop      = ce & outValid & outReady;

   always @(posedge clk)
   begin
      if (push)
      begin
         mem[wrPtr] <= inData;
      end
   end

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wrPtr <= {ADDR_W{1'b0}};
         rdPtr <= {ADDR_W{1'b0}};
         count <= {(ADDR_W+1){1'b0}};
      end
      else
      begin
         if (push)
         begin
            wrPtr <= wrPtr + 1'b1;
         end
         if (pop)
         begin
            rdPtr <= rdPtr + 1'b1;
         end
         if (push & ~pop)
         begin
            count <= count + 1'b1;
         end
         else if (pop & ~push)
         begin
            count <= count - 1'b1;
         end
      end
   end
endmodule

// *** logic/ddr_tx_parallel_capture.v ***
// transmit parallel capture for pairs C/D, E/F, G/H with APB control
//
// Implementation choices: the register addresses and the APB register port.
`include "ddr_capture_regs.vh"

module ddr_tx_parallel_capture #(
   parameter FIFO_DEPTH = `CAP_FIFO_DEPTH,
   parameter FIFO_AW    = `CAP_FIFO_AW
) (
   input  wire        mclk,
   input  wire        rst,
   input  wire        ce,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        sharedTxClock,
   input  wire        txClockPairCd,
   input  wire        txClockPairEf,
   input  wire        txClockPairGh,
   input  wire [9:0]  txBusPairCd,
   input  wire [9:0]  txBusPairEf,
   input  wire [9:0]  txBusPairGh,
   output reg  [2:0]  outValid,
   input  wire [2:0]  outReady,
   output reg  [29:0] firstWord,
   output reg  [2:0]  firstK,
   output reg  [29:0] secondWord,
   output reg  [2:0]  secondK,
   output reg         encodeOn
);

   // ----------------------------------------------------------------------------
   // word formatting
   // ----------------------------------------------------------------------------
   // multiplexed slot: {k, word[9:0]}
   function [10:0] muxWord;
      input [9:0] b;
      input       code;
      begin
         if (code)
            muxWord = {b[8], 2'b00, b[7:0]};
         else
            muxWord = {1'b0, b};
      end
   endfunction

   // nibble slot: lo from the falling edge, hi from the rising edge
   function [10:0] nibWord;
      input [4:0] lo;
      input [4:0] hi;
      input       code;
      begin
         if (code)
            nibWord = {lo[3], 2'b00, hi[4], hi[2:0], lo[4], lo[2:0]};
         else
            nibWord = {1'b0, hi, lo};
      end
   endfunction

   // ----------------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------------
   reg  [`CAP_CTRL_WIDTH-1:0] ctrl;
   reg  [2:0]                 overflow;
   wire [2:0]                 ovfEvent;
   wire [2:0]                 fifoEmpty;
   wire [2:0]                 fifoFull;
   wire [3*(FIFO_AW+1)-1:0]   fifoLevel;

   wire nibbleMode = ctrl[`CAP_CTRL_NIBBLE];
   wire indepMode  = ctrl[`CAP_CTRL_INDEP];
   wire codeMode   = ctrl[`CAP_CTRL_CODE];
   wire capEnable  = ctrl[`CAP_CTRL_ENABLE];

   wire setupPhase = psel & ~penable;
   wire wrAccess   = psel & penable & pwrite & pready;
   wire ctrlHit    = (paddr == `CAP_OFS_CTRL);
   wire statHit    = (paddr == `CAP_OFS_STATUS);
   wire levelHit   = (paddr == `CAP_OFS_LEVEL);

   reg  [31:0] readMux;
   reg  [31:0] levelWord;
   integer     li;

   always @*
   begin
      levelWord = 32'h0000_0000;
      for (li = 0; li < 3; li = li + 1)
      begin
         levelWord[li*`CAP_LEVEL_STRIDE +: FIFO_AW+1] =
            fifoLevel[li*(FIFO_AW+1) +: FIFO_AW+1];
      end
      readMux = 32'h0000_0000;
      if (ctrlHit)
      begin
         readMux[`CAP_CTRL_WIDTH-1:0] = ctrl;
      end
      else if (statHit)
      begin
         readMux[`CAP_STAT_OVF_LSB +: 3]   = overflow;
         readMux[`CAP_STAT_EMPTY_LSB +: 3] = fifoEmpty;
         readMux[`CAP_STAT_FULL_LSB +: 3]  = fifoFull;
      end
      else if (levelHit)
      begin
         readMux = levelWord;
      end
   end

   // read data and error settle during setup so the access phase sees them
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         prdata   <= 32'h0000_0000;
         pready   <= 1'b1;
         pslverr  <= 1'b0;
         ctrl     <= `CAP_CTRL_RESET;
         overflow <= 3'h0;
         encodeOn <= 1'b0;
      end
      else if (ce)
      begin
         if (setupPhase)
         begin
            prdata  <= pwrite ? 32'h0000_0000 : readMux;
            pslverr <= ~(ctrlHit | statHit | levelHit);
         end
         if (wrAccess & ctrlHit)
         begin
            ctrl <= pwdata[`CAP_CTRL_WIDTH-1:0];
         end
         // sticky drop flags: a new drop beats a write-one clear
         if (wrAccess & statHit)
            overflow <= (overflow & ~pwdata[`CAP_STAT_OVF_LSB +: 3]) | ovfEvent;
         else
            overflow <= overflow | ovfEvent;
         encodeOn <= codeMode;
      end
   end

   // ----------------------------------------------------------------------------
   // pin synchronisers and clock edge detect
   // ----------------------------------------------------------------------------
   wire [3:0]  clkPins = {txClockPairGh, txClockPairEf, txClockPairCd, sharedTxClock};
   wire [29:0] busPins = {txBusPairGh, txBusPairEf, txBusPairCd};
   reg  [3:0]  clkSync1;
   reg  [3:0]  clkSync2;
   reg  [3:0]  clkSync3;
   reg  [29:0] busSync1;
   reg  [29:0] busSync2;

   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         // clock pins idle high, so no false edge follows reset
         clkSync1 <= 4'hf;
         clkSync2 <= 4'hf;
         clkSync3 <= 4'hf;
         busSync1 <= 30'h0000_0000;
         busSync2 <= 30'h0000_0000;
      end
      else if (ce)
      begin
         clkSync1 <= clkPins;
         clkSync2 <= clkSync1;
         clkSync3 <= clkSync2;
         busSync1 <= busPins;
         busSync2 <= busSync1;
      end
   end

   wire [3:0] clkRise = clkSync2 & ~clkSync3;
   wire [3:0] clkFall = ~clkSync2 & clkSync3;

   // ----------------------------------------------------------------------------
   // per pair capture, fifo and output stage
   // ----------------------------------------------------------------------------
   genvar p;
   generate
      for (p = 0; p < `CAP_PAIRS; p = p + 1)
      begin : pairs
         wire [9:0]  bus = busSync2[p*10 +: 10];
         wire        useOwn  = indepMode;
         wire        selRise = useOwn ? clkRise[p+1] : clkRise[0];
         wire        selFall = useOwn ? clkFall[p+1] : clkFall[0];
         reg  [9:0]  fallHold;
         reg         haveFall;
         reg         pushValid;
         reg  [21:0] pushData;
         wire        pushReady;
         wire        popValid;
         wire [21:0] popData;
         wire        popReady = ~outValid[p] | outReady[p];
         reg  [10:0] slotFirst;
         reg  [10:0] slotSecond;

         always @*
         begin
            slotFirst  = 11'h000;
            slotSecond = 11'h000;
            if (nibbleMode)
            begin
               slotFirst  = nibWord(fallHold[4:0], bus[4:0], codeMode);
               slotSecond = nibWord(fallHold[9:5], bus[9:5], codeMode);
            end
            else
            begin
               slotFirst  = muxWord(fallHold, codeMode);
               slotSecond = muxWord(bus, codeMode);
            end
         end

         always @(posedge mclk or posedge rst)
         begin
            if (rst)
            begin
               fallHold  <= 10'h000;
               haveFall  <= 1'b0;
               pushValid <= 1'b0;
               pushData  <= 22'h00_0000;
            end
            else if (ce)
            begin
               pushValid <= 1'b0;
               if (~capEnable)
               begin
                  haveFall <= 1'b0;
               end
               else if (selFall)
               begin
                  fallHold <= bus;
                  haveFall <= 1'b1;
               end
               else if (selRise & haveFall)
               begin
                  haveFall  <= 1'b0;
                  pushValid <= 1'b1;
                  pushData  <= {slotSecond, slotFirst};
               end
            end
         end

         // a full fifo drops the pair and flags it
         assign ovfEvent[p]  = pushValid & ~pushReady;
         assign fifoEmpty[p] = ~popValid;
         assign fifoFull[p]  = ~pushReady;

         capture_fifo #(
            .WIDTH  (22),
            .DEPTH  (FIFO_DEPTH),
            .ADDR_W (FIFO_AW)
         ) fifo (
            .clk      (mclk),
            .rst      (rst),
            .ce       (ce),
            .inValid  (pushValid),
            .inReady  (pushReady),
            .inData   (pushData),
            .outValid (popValid),
            .outReady (popReady),
            .outData  (popData),
            .level    (fifoLevel[p*(FIFO_AW+1) +: FIFO_AW+1])
         );

         always @(posedge mclk or posedge rst)
         begin
            if (rst)
            begin
               outValid[p]           <= 1'b0;
               firstWord[p*10 +: 10] <= 10'h000;
               firstK[p]             <= 1'b0;
               secondWord[p*10 +: 10] <= 10'h000;
               secondK[p]            <= 1'b0;
            end
            else if (ce)
            begin
               if (popReady)
               begin
                  outValid[p] <= popValid;
                  if (popValid)
                  begin
                     firstWord[p*10 +: 10]  <= popData[9:0];
                     firstK[p]              <= popData[10];
                     secondWord[p*10 +: 10] <= popData[20:11];
                     secondK[p]             <= popData[21];
                  end
               end
            end
         end
      end
   endgenerate

endmodule

// *** tb/ddr_capture_assertions.sv ***
// port assertions of the transmit parallel capture
`include "ddr_capture_regs.vh"
module ddr_capture_checker (
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        ce,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [2:0]  outValid,
   input wire logic [2:0]  outReady,
   input wire logic [29:0] firstWord,
   input wire logic [2:0]  firstK,
   input wire logic [29:0] secondWord,
   input wire logic [2:0]  secondK,
   input wire logic        encodeOn
);
   logic hit;
   assign hit = paddr == `CAP_OFS_CTRL || paddr == `CAP_OFS_STATUS
      || paddr == `CAP_OFS_LEVEL;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   sequence setup;
      psel && !penable && ce;
   endsequence
   sequence ctrlWrite;
      psel && penable && pwrite && ce && paddr == `CAP_OFS_CTRL;
   endsequence
   property codeFollow;
      logic c;
      (ctrlWrite, c = pwdata[2]) |-> ##2 encodeOn == c;
   endproperty
   a_ready_high: assert property (pready)
      else $error("pready low");
   a_err_unmapped: assert property (setup ##0 !hit |=> pslverr)
      else $error("no error on unmapped access");
   a_err_mapped: assert property (setup ##0 hit |=> !pslverr)
      else $error("error on mapped access");
   a_read_zero: assert property (setup ##0 (pwrite || !hit) |=> prdata == 32'h0)
      else $error("read data not zero");
   a_code_follow: assert property (codeFollow)
      else $error("encode flag does not follow control");
   a_valid_hold: assert property (outValid[0] && !outReady[0] && ce |=>
      outValid[0] && $stable(firstWord[9:0]) && $stable(secondWord[9:0]))
      else $error("output pair changed while stalled");
   a_code_upper: assert property (encodeOn && outValid[0] |->
      firstWord[9:8] == 2'h0 && secondWord[9:8] == 2'h0)
      else $error("encoded word has upper bits");
   a_raw_nok: assert property (!encodeOn |-> ((firstK | secondK) & outValid) == 3'h0)
      else $error("K flag in raw mode");
endmodule

bind ddr_tx_parallel_capture ddr_capture_checker chk (.mclk(mclk), .rst(rst), .ce(ce),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .outValid(outValid),
   .outReady(outReady), .firstWord(firstWord), .firstK(firstK),
   .secondWord(secondWord), .secondK(secondK), .encodeOn(encodeOn));

// *** tb/ddr_tx_parallel_capture_tb.sv ***
// self-checking bench for the transmit parallel capture
`include "ddr_capture_regs.vh"
module ddr_tx_parallel_capture_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk, rst, ce, psel, penable, pwrite, code, err;
   logic        pready, pslverr, sharedTxClock, encodeOn;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0]  pairClock, outValid, outReady, firstK, secondK;
   logic [29:0] bus, firstWord, secondWord, fa, ra;
   logic [9:0]  fb, rb;
   int          errorCnt, testsRun, cycles;

   ddr_tx_parallel_capture DUT (.mclk(mclk), .rst(rst), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .sharedTxClock(sharedTxClock),
      .txClockPairCd(pairClock[0]), .txClockPairEf(pairClock[1]),
      .txClockPairGh(pairClock[2]), .txBusPairCd(bus[9:0]), .txBusPairEf(bus[19:10]),
      .txBusPairGh(bus[29:20]), .outValid(outValid), .outReady(outReady),
      .firstWord(firstWord), .firstK(firstK), .secondWord(secondWord),
      .secondK(secondK), .encodeOn(encodeOn));
   tx_source_model far (.sharedTxClock(sharedTxClock), .pairClock(pairClock), .bus(bus));

   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 8000)
      begin
         errorCnt++;
         finalReport;
      end
   end
   // --------
   // tasks
   // --------
   task automatic finalReport;
      if (errorCnt == 0 && testsRun > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      testsRun++;
      if (seen !== want)
      begin
         errorCnt++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic ctrl(input logic [3:0] v);
      apb(1'b1, `CAP_OFS_CTRL, 32'(v));
      apb(1'b0, `CAP_OFS_CTRL, 32'h0);
      check(rd, 32'(v));
      check(32'(encodeOn), 32'(v[2]));
      code = v[2];
   endtask
   task automatic take(input int p, input logic [9:0] w1, input logic k1,
      input logic [9:0] w2, input logic k2);
      @(posedge mclk);
      while (outValid[p] !== 1'b1) @(posedge mclk);
      check(32'(firstWord[p*10+:10]), 32'(w1));
      check(32'(secondWord[p*10+:10]), 32'(w2));
      check(32'({firstK[p], secondK[p]}), 32'({k1, k2}));
      outReady <= 3'(1 << p);
      @(posedge mclk);
      outReady <= 3'h0;
   endtask
   task automatic pair(input int p, input logic own, input logic [9:0] w1, input logic k1,
      input logic [9:0] w2, input logic k2);
      far.sendPair(p, own, code, fb, rb);
      take(p, w1, k1, w2, k2);
   endtask
   function automatic logic [9:0] nib(input logic [4:0] lo, input logic [4:0] hi);
      return {2'h0, hi[4], hi[2:0], lo[4], lo[2:0]};
   endfunction
   // --------
   // tests
   // --------
   initial
   begin
      rst = 1'b1;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      outReady = 3'h0;
      code = 1'b0;
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      apb(1'b0, `CAP_OFS_CTRL, 32'h0);
      check(rd, 32'h0);
      apb(1'b1, 12'hffc, 32'hf);
      check(32'(err), 32'h1);
      apb(1'b0, 12'hffc, 32'h0);
      check(rd, 32'h0);
      // the shared clock latches every pair, so one frame feeds all three
      ctrl(4'h8);
      for (int p = 0; p < 3; p++)
      begin
         fa[p*10+:10] = 10'h3c5 ^ 10'(p);
         ra[p*10+:10] = 10'h15a ^ 10'(p << 4);
      end
      far.sendAll(3'h0, code, fa, ra);
      for (int p = 0; p < 3; p++)
         take(p, fa[p*10+:10], 1'b0, ra[p*10+:10], 1'b0);
      ctrl(4'hc);
      for (int p = 0; p < 3; p++)
      begin
         fa[p*10+:10] = 10'h3a5 ^ 10'(p);
         ra[p*10+:10] = 10'h03c ^ 10'(p << 7);
      end
      far.sendAll(3'h0, code, fa, ra);
      for (int p = 0; p < 3; p++)
         take(p, {2'h0, fa[p*10+:8]}, fa[p*10+8],
            {2'h0, ra[p*10+:8]}, ra[p*10+8]);
      ctrl(4'h9);
      for (int p = 0; p < 3; p++)
      begin
         fa[p*10+:10] = 10'h2b6 ^ 10'(p);
         ra[p*10+:10] = 10'h1c9 ^ 10'(p << 5);
      end
      far.sendAll(3'h0, code, fa, ra);
      for (int p = 0; p < 3; p++)
         take(p, {ra[p*10+:5], fa[p*10+:5]}, 1'b0,
            {ra[p*10+5+:5], fa[p*10+5+:5]}, 1'b0);
      ctrl(4'hd);
      for (int p = 0; p < 3; p++)
      begin
         fa[p*10+:10] = (p[0] ? 10'h1ad : 10'h0f2) ^ 10'(p << 1);
         ra[p*10+:10] = 10'h0e7 ^ 10'(p << 6);
      end
      far.sendAll(3'h0, code, fa, ra);
      for (int p = 0; p < 3; p++)
         take(p, nib(fa[p*10+:5], ra[p*10+:5]), fa[p*10+3],
            nib(fa[p*10+5+:5], ra[p*10+5+:5]), fa[p*10+8]);
      ctrl(4'ha);
      for (int p = 0; p < 3; p++)
      begin
         far.sendPair(p, 1'b0, 1'b0, 10'h3ff, 10'h3ff);
         fb = 10'h12c ^ 10'(p);
         rb = 10'h2d3;
         pair(p, 1'b1, fb, 1'b0, rb, 1'b0);
      end
      ctrl(4'h8);
      for (int i = 0; i < 18; i++)
         far.sendPair(0, 1'b0, 1'b0, 10'(i), 10'(i + 40));
      apb(1'b0, `CAP_OFS_LEVEL, 32'h0);
      check(32'(rd[4:0]), 32'h10);
      apb(1'b0, `CAP_OFS_STATUS, 32'h0);
      check(rd & 32'h111, 32'h101);
      apb(1'b1, `CAP_OFS_STATUS, 32'h1);
      apb(1'b0, `CAP_OFS_STATUS, 32'h0);
      check(rd & 32'h1, 32'h0);
      // a frozen block must not pop although the consumer is ready
      ce <= 1'b0;
      outReady <= 3'h1;
      repeat (3) @(posedge mclk);
      ce <= 1'b1;
      outReady <= 3'h0;
      for (int i = 0; i < 17; i++)
         take(0, 10'(i), 1'b0, 10'(i + 40), 1'b0);
      apb(1'b0, `CAP_OFS_STATUS, 32'h0);
      check(rd & 32'h111, 32'h010);
      finalReport;
   end
endmodule

// *** tb/tx_source_model.sv ***
// protocol device model driving transmit clocks and pair buses
module tx_source_model (
   output logic        sharedTxClock,
   output logic [2:0]  pairClock,
   output logic [29:0] bus
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      sharedTxClock = 1'b1;
      pairClock = 3'h7;
      bus = 30'h0;
   end
   // sel empty: shared clock; otherwise the pair clocks named in sel
   task automatic edgeTo(input logic [2:0] sel, input logic v);
      if (sel == 3'h0)
         sharedTxClock = v;
      else
         pairClock = v ? (pairClock | sel) : (pairClock & ~sel);
   endtask
   // fall then rise, every change 2 ns clear of an mclk edge
   task automatic sendAll(input logic [2:0] sel, input logic code,
      input logic [29:0] fv, input logic [29:0] rv);
      logic [29:0] rel;
      for (int q = 0; q < 3; q++)
      begin
         fv[q*10+9] = fv[q*10+9] & !code;
         rv[q*10+9] = rv[q*10+9] & !code;
         // released lines: inverse of last value, line nine pulled down
         rel[q*10+:10] = {1'b0, ~rv[q*10+:9]};
      end
      #2;
      bus = fv;
      #20;
      edgeTo(sel, 1'b0);
      #20;
      bus = rv;
      #20;
      edgeTo(sel, 1'b1);
      #16;
      bus = rel;
      #2;
   endtask
   // one pair's frame; the other pair buses hold what they show through both edges, then release inverted
   task automatic sendPair(input int p, input logic own, input logic code,
      input logic [9:0] fb, input logic [9:0] rb);
      logic [29:0] fv;
      logic [29:0] rv;
      fv = bus;
      rv = bus;
      fv[p*10+:10] = fb;
      rv[p*10+:10] = rb;
      sendAll(own ? 3'(1 << p) : 3'h0, code, fv, rv);
   endtask
endmodule
